// file: rtl/cascaded_timer16.sv
// cascaded 16-bit timer: event count, pwm, pulse generator and warm-up modes
`timescale 1ns/100ps
`default_nettype none
`include "timer16_regs.svh"

module cascaded_timer16
   import timer16_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire mode_t       mode_in,
   input  wire logic        run_bit_in,
   input  wire logic        toggle_initial_value_bit_in,
   input  wire logic        ext_clock_sel_in,
   input  wire logic        prescaled_tick_in,
   input  wire logic        event_input_pin_in,
   input  wire byte_wr_t    period_wr_in,
   input  wire byte_wr_t    duty_wr_in,
   output logic             match_interrupt_out,
   output logic             pwm_output_pin_out,
   output logic             pulse_gen_output_pin_out,
   output logic [15:0]      count_out,
   output logic [15:0]      period_rd_out,
   output logic [15:0]      duty_rd_out
);

   //------------------------------------------------------------
   // state
   //------------------------------------------------------------
   logic        evt_prev_r;
   logic [7:0]  cnt_lo_r,     cnt_lo_nxt;
   logic [7:0]  cnt_hi_r,     cnt_hi_nxt;
   logic [15:0] period_r,     period_nxt;
   logic [15:0] duty_buf_r,   duty_buf_nxt;
   logic [15:0] duty_act_r,   duty_act_nxt;
   logic [15:0] duty_rd_r,    duty_rd_nxt;
   logic        flop_r,       flop_nxt;
   logic        init_prev_r;
   logic        irq_r,        irq_nxt;
   logic        pwm_pin_r,    pwm_pin_nxt;
   logic        ppg_pin_r,    ppg_pin_nxt;

   logic        evt_fall;
   logic        step;
   logic [8:0]  lo_inc;
   logic [7:0]  hi_inc;
   logic [15:0] count;
   logic [15:0] next_cnt;
   logic        clear;
   logic        tog_a;
   logic        tog_b;

   //------------------------------------------------------------
   // count enable and cascaded increment
   //------------------------------------------------------------
   // falling edge of the event pin; each level lasts two cycles at least
   assign evt_fall = evt_prev_r & ~event_input_pin_in;

   always_comb begin
      step = 1'b0;
      if (run_bit_in) begin
         unique case (mode_in)
            MODE_EVENT:                step = evt_fall;
            MODE_PWM, MODE_PULSE_GEN:  step = ext_clock_sel_in ? evt_fall : prescaled_tick_in;
            default:                   step = prescaled_tick_in;
         endcase
      end
   end

   // low byte carry feeds the high byte
   assign count    = {cnt_hi_r, cnt_lo_r};
   assign lo_inc   = {1'b0, cnt_lo_r} + `T16_BYTE_ONE;
   assign hi_inc   = cnt_hi_r + {7'h00, lo_inc[8]};
   assign next_cnt = {hi_inc, lo_inc[7:0]};

   //------------------------------------------------------------
   // match detection per mode
   //------------------------------------------------------------
   always_comb begin
      clear = 1'b0;
      tog_a = 1'b0;
      tog_b = 1'b0;
      if (step) begin
         unique case (mode_in)
            MODE_EVENT: begin
               clear = (next_cnt == period_r);
            end
            MODE_PWM: begin
               if (count == `T16_COUNT_MAX) begin
                  clear = 1'b1;
                  tog_a = 1'b1;
               end else begin
                  tog_a = (next_cnt == duty_act_r);
               end
            end
            MODE_PULSE_GEN: begin
               tog_a = (next_cnt == duty_buf_r);
               clear = (next_cnt == period_r);
               tog_b = clear;
            end
            MODE_WARM_TO_LOW, MODE_WARM_TO_HIGH: begin
               clear = (next_cnt[15:8] == period_r[15:8]);
            end
            default: begin
               clear = 1'b0;
            end
         endcase
      end
   end

   //------------------------------------------------------------
   // next values of counter, registers, flop and pins
   //------------------------------------------------------------
   always_comb begin
      cnt_lo_nxt   = cnt_lo_r;
      cnt_hi_nxt   = cnt_hi_r;
      period_nxt   = period_r;
      duty_buf_nxt = duty_buf_r;
      flop_nxt     = flop_r;
      irq_nxt      = clear;

      // counter advances or clears on a step only
      if (step) begin
         if (clear) begin
            cnt_lo_nxt = 8'(`T16_COUNT_RST);
            cnt_hi_nxt = 8'(`T16_COUNT_RST >> 8);
         end else begin
            cnt_lo_nxt = next_cnt[7:0];
            cnt_hi_nxt = next_cnt[15:8];
         end
      end

      // period writes land at once, no shadow
      if (period_wr_in.wr_low) period_nxt[7:0] = period_wr_in.data;
      if (period_wr_in.wr_high) period_nxt[15:8] = period_wr_in.data;
      if (duty_wr_in.wr_low) duty_buf_nxt[7:0] = duty_wr_in.data;
      if (duty_wr_in.wr_high) duty_buf_nxt[15:8] = duty_wr_in.data;

      // toggle flop: inverts on matches, loads initial bit only while stopped
      if (run_bit_in) begin
         flop_nxt = flop_r ^ tog_a ^ tog_b;
      end else if (toggle_initial_value_bit_in != init_prev_r) begin
         flop_nxt = toggle_initial_value_bit_in;
      end

      // pwm duty: shadowed while running, immediate while stopped
      if (mode_in == MODE_PWM && run_bit_in) begin
         duty_act_nxt = clear ? duty_buf_r : duty_act_r;
      end else begin
         duty_act_nxt = duty_buf_nxt;
      end

      // running pwm reads the active value, else the written value
      duty_rd_nxt = (mode_in == MODE_PWM && run_bit_in) ? duty_act_nxt : duty_buf_nxt;

      pwm_pin_nxt = ~flop_nxt;
      ppg_pin_nxt = ~flop_nxt;
   end

   //------------------------------------------------------------
   // registers
   //------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         evt_prev_r  <= 1'b1;
         cnt_lo_r    <= 8'h00;
         cnt_hi_r    <= 8'h00;
         period_r    <= `T16_REG_RST;
         duty_buf_r  <= `T16_REG_RST;
         duty_act_r  <= `T16_REG_RST;
         duty_rd_r   <= `T16_REG_RST;
         flop_r      <= `T16_FLOP_RST;
         init_prev_r <= `T16_FLOP_RST;
         irq_r       <= 1'b0;
         pwm_pin_r   <= ~`T16_FLOP_RST;
         ppg_pin_r   <= ~`T16_FLOP_RST;
      end else begin
         evt_prev_r  <= event_input_pin_in;
         cnt_lo_r    <= cnt_lo_nxt;
         cnt_hi_r    <= cnt_hi_nxt;
         period_r    <= period_nxt;
         duty_buf_r  <= duty_buf_nxt;
         duty_act_r  <= duty_act_nxt;
         duty_rd_r   <= duty_rd_nxt;
         flop_r      <= flop_nxt;
         init_prev_r <= toggle_initial_value_bit_in;
         irq_r       <= irq_nxt;
         pwm_pin_r   <= pwm_pin_nxt;
         ppg_pin_r   <= ppg_pin_nxt;
      end
   end

   // outputs straight from flops
   assign match_interrupt_out      = irq_r;
   assign pwm_output_pin_out       = pwm_pin_r;
   assign pulse_gen_output_pin_out = ppg_pin_r;
   assign count_out                = {cnt_hi_r, cnt_lo_r};
   assign period_rd_out            = period_r;
   assign duty_rd_out              = duty_rd_r;

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   event_step_a: assert property (
      run_bit_in && mode_in == MODE_EVENT && evt_fall && next_cnt != period_r
      |=> count_out == 16'($past(count_out) + 16'h0001))
      else $error("event count did not advance by one");

   event_match_a: assert property (
      run_bit_in && mode_in == MODE_EVENT && evt_fall && next_cnt == period_r
      |=> match_interrupt_out && count_out == 16'h0000)
      else $error("event match missed interrupt or clear");

   count_hold_a: assert property (
      !step |=> $stable(count_out))
      else $error("counter moved without a count step");

   pwm_wrap_a: assert property (
      mode_in == MODE_PWM && step && count == 16'hffff
      |=> match_interrupt_out && count_out == 16'h0000
          && pwm_output_pin_out != $past(pwm_output_pin_out))
      else $error("pwm overflow did not toggle, clear and interrupt");

   pin_inverse_a: assert property (
      pwm_output_pin_out == ~flop_r && pulse_gen_output_pin_out == ~flop_r)
      else $error("output pin not inverse of toggle flop");

   stop_hold_a: assert property (
      !run_bit_in && toggle_initial_value_bit_in == init_prev_r
      |=> $stable(pwm_output_pin_out) && $stable(pulse_gen_output_pin_out))
      else $error("stopped counter changed the pin");

   flop_load_a: assert property (
      !run_bit_in && toggle_initial_value_bit_in != init_prev_r
      |=> flop_r == $past(toggle_initial_value_bit_in))
      else $error("toggle flop did not load initial bit");

   shadow_hold_a: assert property (
      mode_in == MODE_PWM && run_bit_in && !clear |=> $stable(duty_act_r))
      else $error("running pwm duty changed before interrupt");

   duty_read_a: assert property (
      mode_in == MODE_PWM && run_bit_in && !clear |=> $stable(duty_rd_out))
      else $error("running pwm read did not return active duty");

   ppg_period_a: assert property (
      mode_in == MODE_PULSE_GEN && step && next_cnt == period_r && next_cnt != duty_buf_r
      |=> match_interrupt_out && count_out == 16'h0000
          && pulse_gen_output_pin_out != $past(pulse_gen_output_pin_out))
      else $error("pulse period match misbehaved");

   warm_match_a: assert property (
      (mode_in == MODE_WARM_TO_LOW || mode_in == MODE_WARM_TO_HIGH) && step
      && next_cnt[15:8] == period_r[15:8]
      |=> match_interrupt_out && count_out == 16'h0000)
      else $error("warm-up high byte match missed");

endmodule
`default_nettype wire

// file: rtl/timer16_regs.svh
// reset values and limits of the cascaded 16-bit timer
`ifndef TIMER16_REGS_SVH
`define TIMER16_REGS_SVH

`define T16_COUNT_RST 16'h0000
`define T16_REG_RST   16'h0000
`define T16_FLOP_RST  1'b0
`define T16_COUNT_MAX 16'hffff
`define T16_BYTE_ONE  9'h001

`endif

// file: rtl/timer16_pkg.sv
// types shared by the cascaded 16-bit timer
package timer16_pkg;

   // operating modes of the cascaded counter
   typedef enum logic [2:0] {
      MODE_EVENT,
      MODE_PWM,
      MODE_PULSE_GEN,
      MODE_WARM_TO_LOW,
      MODE_WARM_TO_HIGH
   } mode_t;

   // one byte write to a 16-bit register, low or high half
   typedef struct packed {
      logic       wr_low;
      logic       wr_high;
      logic [7:0] data;
   } byte_wr_t;

endpackage

// file: test/event_source.sv
// partner model: external event source driving the count input pin
`timescale 1ns/100ps
`default_nettype none
module event_source (
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       fire_in,
   input  wire logic [2:0] hold_in,
   output logic            pin_out,
   output logic            busy_out
);
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   logic [3:0] h;
   logic       pin_nxt;
   // one low then high pulse, each level held at least two cycles, idle high
   always_comb begin
      h = (hold_in < 3'h2) ? 4'h2 : {1'b0, hold_in};
      cnt_nxt = cnt_r;
      pin_nxt = pin_out;
      if (cnt_r == 4'h0 && fire_in) begin
         cnt_nxt = {h[2:0], 1'b0};
         pin_nxt = 1'b0;
      end else if (cnt_r != 4'h0) begin
         cnt_nxt = cnt_r - 4'h1;
         pin_nxt = (cnt_nxt > h) ? 1'b0 : 1'b1;
      end
   end
   // register the pulse state
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cnt_r   <= 4'h0;
         pin_out <= 1'b1;
      end else begin
         cnt_r   <= cnt_nxt;
         pin_out <= pin_nxt;
      end
   end
   assign busy_out = (cnt_r != 4'h0);
endmodule
`default_nettype wire

// file: test/tb.sv
// self-checking bench for the cascaded 16-bit timer
`timescale 1ns/100ps
`default_nettype none
module tb
   import timer16_pkg::*;
;
   logic        clk_in, rst_in, run, tbit, esel, tick, fire, ev_pin, busy;
   logic        irq, pwm_pin, pg_pin;
   logic [15:0] cnt, per_rd, duty_rd, v;
   logic [2:0]  hold;
   mode_t       mode;
   byte_wr_t    per_wr, duty_wr;
   int          miscompares = 0, check_count = 0, irqs = 0, p, d, g;

   cascaded_timer16 uut (.clk_in(clk_in), .rst_in(rst_in), .mode_in(mode), .run_bit_in(run),
      .toggle_initial_value_bit_in(tbit), .ext_clock_sel_in(esel), .prescaled_tick_in(tick),
      .event_input_pin_in(ev_pin), .period_wr_in(per_wr), .duty_wr_in(duty_wr),
      .match_interrupt_out(irq), .pwm_output_pin_out(pwm_pin), .pulse_gen_output_pin_out(pg_pin),
      .count_out(cnt), .period_rd_out(per_rd), .duty_rd_out(duty_rd));
   event_source src (.clk_in(clk_in), .rst_in(rst_in), .fire_in(fire), .hold_in(hold),
      .pin_out(ev_pin), .busy_out(busy));

   // clock and interrupt pulse counter
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) if (irq === 1'b1) irqs <= irqs + 1;

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   // 16-bit register write, low byte then high byte
   task automatic wr(input bit dt, input logic [15:0] val);
      @(posedge clk_in);
      if (dt) duty_wr <= {2'b10, val[7:0]}; else per_wr <= {2'b10, val[7:0]};
      @(posedge clk_in);
      if (dt) duty_wr <= {2'b01, val[15:8]}; else per_wr <= {2'b01, val[15:8]};
      @(posedge clk_in);
      duty_wr <= '0;
      per_wr <= '0;
      @(negedge clk_in);
   endtask
   // n event pulses from the partner, random level lengths
   task automatic ev(input int n);
      int k;
      repeat (n) begin
         @(posedge clk_in);
         fire <= 1'b1;
         hold <= 3'($urandom);
         @(posedge clk_in);
         fire <= 1'b0;
         k = 0;
         // busy is read on falling edges, once the pulse state has settled
         @(negedge clk_in);
         while (busy && k < 40) begin
            @(negedge clk_in);
            k++;
         end
         if (busy) miscompares++; // pulse never ended
      end
   endtask
   function automatic logic pg_exp(int i, int dd, int pp);
      return ((i % pp) >= dd) ? 1'b0 : 1'b1;
   endfunction

   // watchdog
   initial begin
      cyc(90000);
      miscompares++;
      results;
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(18440));
      {rst_in, run, tbit, esel, tick, fire} = 6'h20;
      hold    = 3'h2;
      per_wr  = '0;
      duty_wr = '0;
      mode = MODE_EVENT;
      cyc(20);
      rst_in <= 1'b0;
      @(negedge clk_in);
      chk(cnt, 16'h0000);
      chk(16'({irq, pwm_pin, pg_pin}), 16'h0003);
      chk(per_rd | duty_rd, 16'h0000);
      // event counting up to the period
      p = 3 + $urandom % 5;
      wr(0, 16'(p));
      chk(per_rd, 16'(p));
      @(posedge clk_in) run <= 1'b1;
      for (int i = 1; i <= p; i++) begin
         ev(1);
         chk(cnt, 16'(i % p));
      end
      chk(16'(irqs), 16'h0001);
      // warm-up, both variants, period low byte random
      for (int m = 0; m < 2; m++) begin
         @(posedge clk_in) run <= 1'b0;
         mode <= m ? MODE_WARM_TO_HIGH : MODE_WARM_TO_LOW;
         tbit <= 1'b0;
         tick <= 1'b1;
         v = {8'h01, 8'($urandom)};
         wr(0, v);
         g = irqs;
         @(posedge clk_in) run <= 1'b1;
         cyc(255);
         run <= 1'b0;
         @(negedge clk_in);
         chk(cnt, 16'h00ff);
         chk(16'(irqs - g), 16'h0000);
         @(posedge clk_in) run <= 1'b1;
         @(posedge clk_in) run <= 1'b0;
         @(negedge clk_in);
         chk(cnt, 16'h0000);
         @(negedge clk_in);
         chk(16'(irqs - g), 16'h0001);
      end
      // pulse generator clocked by the event pin
      @(posedge clk_in) mode <= MODE_PULSE_GEN;
      esel <= 1'b1;
      tick <= 1'b0;
      p = 8 + $urandom % 8;
      d = 2 + $urandom % (p - 3);
      wr(0, 16'(p));
      wr(1, 16'(d));
      g = irqs;
      @(posedge clk_in) run <= 1'b1;
      for (int i = 1; i <= p + d; i++) begin
         ev(1);
         chk(16'(pg_pin), 16'(pg_exp(i, d, p)));
         chk(cnt, 16'(i % p));
      end
      chk(16'(irqs - g), 16'h0001);
      @(posedge clk_in) run <= 1'b0;
      ev(2);
      chk(cnt, 16'(d));
      chk(16'(pg_pin), 16'h0000);
      @(posedge clk_in) tbit <= 1'b1;
      @(posedge clk_in) tbit <= 1'b0;
      cyc(2);
      @(negedge clk_in);
      chk(16'(pg_pin), 16'h0001);
      // second reset, then pwm with a duty change while running
      @(posedge clk_in) rst_in <= 1'b1;
      mode <= MODE_PWM;
      esel <= 1'b0;
      tick <= 1'b1;
      cyc(2);
      rst_in <= 1'b0;
      wr(1, 16'h0010);
      chk(duty_rd, 16'h0010);
      @(posedge clk_in) run <= 1'b1;
      cyc(16);
      run <= 1'b0;
      cyc(5);
      @(negedge clk_in);
      chk(cnt, 16'h0010);
      chk(16'({pwm_pin, pg_pin}), 16'h0000);
      @(posedge clk_in) run <= 1'b1;
      wr(1, 16'h0020);
      chk(duty_rd, 16'h0010);
      g = irqs;
      p = 0;
      while (irqs == g && p < 70000) begin
         @(posedge clk_in);
         p++;
      end
      @(negedge clk_in);
      chk(duty_rd, 16'h0020);
      chk(16'(pwm_pin), 16'h0001);
      chk(16'(irqs - g), 16'h0001);
      results;
   end
endmodule
`default_nettype wire
